// ### hdl/aivf_format.sv
// turns one raw conversion code into a formatted 16-bit result word
`timescale 1ns/1ps
module aivf_format (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        in_valid,
   input  wire logic [3:0]  in_chan,
   input  wire logic [11:0] in_raw,
   input  wire logic        in_over,
   input  wire logic        in_break,
   input  wire logic [3:0]  range_code,
   input  wire logic [1:0]  fmt,
   output logic             out_valid,
   output logic      [3:0]  out_chan,
   output logic      [15:0] out_word
);

   logic        bipolar;
   logic [11:0] signed_val;
   logic [11:0] mag;
   logic [15:0] next_word;

   always_comb begin
      bipolar    = aivf_pkg::aivf_is_bipolar(range_code);
      signed_val = in_raw ^ aivf_pkg::AIVF_MID_CODE;
      mag        = signed_val[11] ? 12'(-signed_val) : signed_val;
      next_word  = aivf_pkg::AIVF_WORD_RST;
      next_word[aivf_pkg::AIVF_BIT_OVER]   = in_over;
      next_word[aivf_pkg::AIVF_BIT_FAULT]  = in_break;
      next_word[aivf_pkg::AIVF_BIT_ACTIVE] = 1'b0;
      if (!bipolar) begin
         next_word[14:3] = in_raw;
      end else begin
         case (fmt)
            aivf_pkg::AIVF_FMT_SIGNMAG: begin
               next_word[aivf_pkg::AIVF_BIT_SIGN] = signed_val[11];
               // -2048 has no 11-bit magnitude; it saturates
               next_word[13:3] = mag[11] ? aivf_pkg::AIVF_MAG_MAX : mag[10:0];
            end
            aivf_pkg::AIVF_FMT_BINARY: begin
               next_word[14:3] = in_raw;
            end
            default: begin
               next_word[aivf_pkg::AIVF_BIT_SIGN] = signed_val[11];
               next_word[13:3] = signed_val[10:0];
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_chan  <= 4'h0;
         out_word  <= aivf_pkg::AIVF_WORD_RST;
      end else begin
         out_valid <= in_valid;
         out_chan  <= in_chan;
         out_word  <= next_word;
      end
   end

endmodule : aivf_format

// ### hdl/aivf_pkg.sv
// shared constants, types and decode helpers for the analog input value formatter
package aivf_pkg;

   // -----------------------------------------------------------------
   // channel and group organisation
   // -----------------------------------------------------------------
   localparam int          AIVF_NUM_RANGES = 12;
   localparam int          AIVF_GROUPS     = 4;
   localparam int          AIVF_CODE_W     = 4;
   localparam int          AIVF_CHANNELS   = 16;
   localparam int          AIVF_RAW_W      = 12;
   localparam int          AIVF_SYNC_W     = 23;

   // -----------------------------------------------------------------
   // result word layout
   // -----------------------------------------------------------------
   localparam int          AIVF_BIT_OVER   = 0;
   localparam int          AIVF_BIT_FAULT  = 1;
   localparam int          AIVF_BIT_ACTIVE = 2;
   localparam int          AIVF_BIT_VAL_LO = 3;
   localparam int          AIVF_BIT_VAL_HI = 14;
   localparam int          AIVF_BIT_SPARE  = 14;
   localparam int          AIVF_BIT_SIGN   = 15;
   localparam logic [15:0] AIVF_WORD_RST   = 16'h0000;
   localparam logic [11:0] AIVF_MID_CODE   = 12'h800;
   localparam logic [10:0] AIVF_MAG_MAX    = 11'h7FF;

   // -----------------------------------------------------------------
   // address map of the result words
   // -----------------------------------------------------------------
   localparam logic [7:0]  AIVF_BASE_FIRST = 8'h80;
   localparam logic [7:0]  AIVF_WIN_DIFF   = 8'h10;
   localparam logic [7:0]  AIVF_WIN_COMMON = 8'h20;
   localparam logic        AIVF_AREA_BASIC = 1'b0;
   localparam logic        AIVF_AREA_EXT   = 1'b1;

   typedef enum logic [3:0] {
      AIVF_RNG_0_20MA  = 4'h0,
      AIVF_RNG_0_1V25  = 4'h1,
      AIVF_RNG_0_2V5   = 4'h2,
      AIVF_RNG_0_5V    = 4'h3,
      AIVF_RNG_0_10V   = 4'h4,
      AIVF_RNG_PM20MA  = 4'h5,
      AIVF_RNG_PM1V25  = 4'h6,
      AIVF_RNG_PM2V5   = 4'h7,
      AIVF_RNG_PM5V    = 4'h8,
      AIVF_RNG_PM10V   = 4'h9,
      AIVF_RNG_4_20MA  = 4'hA,
      AIVF_RNG_1_5V    = 4'hB
   } aivf_range_type;

   typedef enum logic [1:0] {
      AIVF_FMT_TWOS    = 2'b00,
      AIVF_FMT_SIGNMAG = 2'b01,
      AIVF_FMT_BINARY  = 2'b10
   } aivf_fmt_type;

   // one table for every group: bipolar ranges are the five symmetric ones
   function automatic logic aivf_is_bipolar(input logic [3:0] code);
      return (code >= AIVF_RNG_PM20MA) && (code <= AIVF_RNG_PM10V);
   endfunction : aivf_is_bipolar

endpackage : aivf_pkg

// ### hdl/aivf_sync.sv
// three-stage synchroniser with agreement filter for static switch inputs
`timescale 1ns/1ps
module aivf_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge mclk) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a change counts once stage two and three agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync_out <= '0;
      end else if (stage2 == stage3) begin
         sync_out <= stage3;
      end
   end

endmodule : aivf_sync

// ### hdl/aivf_top.sv
// analog input value formatter: switch decode, result RAM and bus read port
`timescale 1ns/1ps

module aivf_top (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [15:0] sw_range,
   input  wire logic [1:0]  sw_fmt,
   input  wire logic        sw_diff,
   input  wire logic        sw_area,
   input  wire logic [2:0]  sw_base,
   input  wire logic        conv_valid,
   input  wire logic [3:0]  conv_chan,
   input  wire logic [11:0] conv_raw,
   input  wire logic        conv_over,
   input  wire logic        conv_break,
   input  wire logic        io_rd,
   input  wire logic        io_area,
   input  wire logic [7:0]  io_addr,
   output logic      [15:0] io_data,
   output logic             io_ack,
   output logic             cfg_error
);

   // ----------------------------------------------------------------
   // switch synchronisation
   // ----------------------------------------------------------------
   logic [22:0] sw_pins;
   logic [22:0] sw_sync;
   logic [15:0] cfg_range;
   logic [1:0]  cfg_fmt;
   logic        cfg_diff;
   logic        cfg_area;
   logic [2:0]  cfg_base;

   assign sw_pins = {sw_range, sw_fmt, sw_diff, sw_area, sw_base};

   aivf_sync #(
      .WIDTH (aivf_pkg::AIVF_SYNC_W)
   ) u_sync (
      .mclk     (mclk),
      .rst      (rst),
      .pin_in   (sw_pins),
      .sync_out (sw_sync)
   );

   assign cfg_range = sw_sync[22:7];
   assign cfg_fmt   = sw_sync[6:5];
   assign cfg_diff  = sw_sync[4];
   assign cfg_area  = sw_sync[3];
   assign cfg_base  = sw_sync[2:0];

   // ----------------------------------------------------------------
   // channel group selection
   // ----------------------------------------------------------------
   logic [1:0]  conv_group;
   logic        conv_ok;
   logic [3:0]  conv_code;
   logic [3:0]  group_code [aivf_pkg::AIVF_GROUPS];

   // every group slices its own range code from the switch word
   generate
      for (genvar g = 0; g < aivf_pkg::AIVF_GROUPS; g++) begin : g_grp
         assign group_code[g] = cfg_range[g*4 +: 4];
      end
   endgenerate

   always_comb begin
      if (cfg_diff) begin
         conv_group = {1'b0, conv_chan[2]};
         conv_ok    = conv_valid && !conv_chan[3];
      end else begin
         conv_group = conv_chan[3:2];
         conv_ok    = conv_valid;
      end
      conv_code = group_code[conv_group];
   end

   // ----------------------------------------------------------------
   // result word formatting
   // ----------------------------------------------------------------
   logic        fmt_valid;
   logic [3:0]  fmt_chan;
   logic [15:0] fmt_word;

   aivf_format u_format (
      .mclk       (mclk),
      .rst        (rst),
      .in_valid   (conv_ok),
      .in_chan    (conv_chan),
      .in_raw     (conv_raw),
      .in_over    (conv_over),
      .in_break   (conv_break),
      .range_code (conv_code),
      .fmt        (cfg_fmt),
      .out_valid  (fmt_valid),
      .out_chan   (fmt_chan),
      .out_word   (fmt_word)
   );

   // ----------------------------------------------------------------
   // result RAM
   // ----------------------------------------------------------------
   logic [15:0] result_ram [aivf_pkg::AIVF_CHANNELS];

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < aivf_pkg::AIVF_CHANNELS; i++) begin
            result_ram[i] <= aivf_pkg::AIVF_WORD_RST;
         end
      end else if (fmt_valid) begin
         result_ram[fmt_chan] <= fmt_word;
      end
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic [2:0]  base_step;
   logic [7:0]  base_byte;
   logic [7:0]  win_size;
   logic [7:0]  rd_offset;
   logic        rd_hit;
   logic [3:0]  rd_chan;

   always_comb begin
      // intermediate bases fall back to the lower one outside differential
      if (cfg_diff) begin
         base_step = cfg_base;
         win_size  = aivf_pkg::AIVF_WIN_DIFF;
      end else begin
         base_step = {cfg_base[2:1], 1'b0};
         win_size  = aivf_pkg::AIVF_WIN_COMMON;
      end
      base_byte = aivf_pkg::AIVF_BASE_FIRST + {1'b0, base_step, 4'h0};
      rd_offset = io_addr - base_byte;
      rd_chan   = rd_offset[4:1];
      if (io_area != cfg_area) begin
         rd_hit = 1'b0;
      end else if (io_addr < base_byte) begin
         rd_hit = 1'b0;
      end else if (rd_offset >= win_size) begin
         rd_hit = 1'b0;
      end else if (io_addr[0]) begin
         rd_hit = 1'b0;
      end else begin
         rd_hit = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         io_ack  <= 1'b0;
         io_data <= aivf_pkg::AIVF_WORD_RST;
      end else if (io_rd && rd_hit) begin
         io_ack  <= 1'b1;
         io_data <= result_ram[rd_chan];
      end else begin
         io_ack  <= 1'b0;
         io_data <= aivf_pkg::AIVF_WORD_RST;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg_error <= 1'b0;
      end else begin
         cfg_error <= !cfg_diff && cfg_base[0];
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb_main @(posedge mclk);
   endclocking

   default disable iff (rst);

   logic conv_bip;
   assign conv_bip = aivf_pkg::aivf_is_bipolar(conv_code);

   property p_store_word;
      fmt_valid |=> (result_ram[$past(fmt_chan)] == $past(fmt_word));
   endproperty
   a_store_word: assert property (p_store_word)
      else $error("result word not stored after conversion");

   property p_read_answer;
      (io_rd && rd_hit) |=> io_ack && (io_data == $past(result_ram[rd_chan]));
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read hit not answered next cycle");

   property p_wrong_area;
      (io_rd && (io_area != cfg_area)) |=> (!io_ack && (io_data == 16'h0000));
   endproperty
   a_wrong_area: assert property (p_wrong_area)
      else $error("read answered in the wrong address area");

   property p_base_common;
      !cfg_diff |-> (base_byte[4] == 1'b0) && (base_byte >= 8'h80);
   endproperty
   a_base_common: assert property (p_base_common)
      else $error("intermediate base used without differential mode");

   property p_overflow;
      (conv_ok && conv_over) |=> (fmt_valid && fmt_word[0]) ##1 result_ram[$past(fmt_chan)][0];
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("overflow bit not carried into stored word");

   property p_fault;
      (conv_ok && conv_break) |=> fmt_word[1];
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault bit missing on broken wire");

   property p_activity;
      io_ack |-> !io_data[2];
   endproperty
   a_activity: assert property (p_activity)
      else $error("activity bit seen set");

   property p_spare_bit;
      (conv_ok && conv_bip && (cfg_fmt != aivf_pkg::AIVF_FMT_BINARY))
         |=> !fmt_word[14];
   endproperty
   a_spare_bit: assert property (p_spare_bit)
      else $error("bit 14 used for a signed bipolar result");

   property p_twos_sign;
      (conv_ok && conv_bip && (cfg_fmt == aivf_pkg::AIVF_FMT_TWOS))
         |=> (fmt_word[15] == ($past(conv_raw) < 12'h800));
   endproperty
   a_twos_sign: assert property (p_twos_sign)
      else $error("sign bit wrong in two's complement result");

   property p_unipolar;
      (conv_ok && !conv_bip) |=> (fmt_word[14:3] == $past(conv_raw)) && !fmt_word[15];
   endproperty
   a_unipolar: assert property (p_unipolar)
      else $error("unipolar value not left aligned from bit 3");

   property p_signmag;
      (conv_ok && conv_bip && (cfg_fmt == aivf_pkg::AIVF_FMT_SIGNMAG))
         |=> (($past(conv_raw) >= 12'h800) ? (fmt_word[13:3] == $past(conv_raw[10:0]))
                                            : fmt_word[15]);
   endproperty
   a_signmag: assert property (p_signmag)
      else $error("sign-magnitude result wrong");

   property p_binary_bip;
      (conv_ok && conv_bip && (cfg_fmt == aivf_pkg::AIVF_FMT_BINARY))
         |=> (fmt_word[14:3] == $past(conv_raw)) && !fmt_word[15];
   endproperty
   a_binary_bip: assert property (p_binary_bip)
      else $error("bipolar binary result not offset coded");

   property p_diff_drop;
      (conv_valid && cfg_diff && conv_chan[3]) |=> !fmt_valid;
   endproperty
   a_diff_drop: assert property (p_diff_drop)
      else $error("upper channel stored in differential mode");

   property p_refused;
      (io_rd && !rd_hit) |=> !io_ack && (io_data == aivf_pkg::AIVF_WORD_RST);
   endproperty
   a_refused: assert property (p_refused)
      else $error("refused read answered");

   property p_cfg_error;
      (!cfg_diff && cfg_base[0]) |=> cfg_error;
   endproperty
   a_cfg_error: assert property (p_cfg_error)
      else $error("odd base step not flagged outside differential mode");

   c_read_hit: cover property (io_rd && rd_hit ##1 io_ack);
   c_overflow: cover property (conv_ok && conv_over ##1 fmt_valid);
   c_signmag:  cover property (conv_ok && conv_bip
                               && (cfg_fmt == aivf_pkg::AIVF_FMT_SIGNMAG));
   c_diff_hi:  cover property (cfg_diff && io_rd && rd_hit && cfg_base[0]);
   c_drop:     cover property (conv_valid && cfg_diff && conv_chan[3]);

endmodule : aivf_top

// ### sim/aivf_cpu_model.sv
// controller-side model that reads result words over the io bus
`timescale 1ns/1ps
module aivf_cpu_model (
   input  wire logic        mclk,
   input  wire logic [15:0] io_data,
   input  wire logic        io_ack,
   output logic             io_rd,
   output logic             io_area,
   output logic      [7:0]  io_addr
);
   initial begin
      io_rd   = 1'b0;
      io_area = 1'b0;
      io_addr = 8'h00;
   end

   // one strobe per word, answer taken one cycle later; released lines show inverted values
   task automatic read_word(input logic area, input logic [7:0] addr,
                            output logic ack, output logic [15:0] data);
      @(posedge mclk);
      io_rd   <= 1'b1;
      io_area <= area;
      io_addr <= addr;
      @(posedge mclk);
      io_rd   <= 1'b0;
      io_area <= ~area;
      io_addr <= ~addr;
      @(posedge mclk);
      ack  = io_ack;
      data = io_data;
   endtask : read_word
endmodule : aivf_cpu_model

// ### sim/test_aivf_top.sv
// self-checking testbench for the analog input value formatter
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module test_aivf_top;
   logic        mclk;
   logic        rst;
   logic [15:0] sw_range;
   logic [1:0]  sw_fmt;
   logic        sw_diff;
   logic        sw_area;
   logic [2:0]  sw_base;
   logic        conv_valid;
   logic [3:0]  conv_chan;
   logic [11:0] conv_raw;
   logic        conv_over;
   logic        conv_break;
   logic        io_rd;
   logic        io_area;
   logic [7:0]  io_addr;
   logic [15:0] io_data;
   logic        io_ack;
   logic        cfg_error;
   int          miscompares;
   int          num_checks;
   logic        ack;
   logic [15:0] data;
   logic [15:0] rng;
   logic [11:0] raw;
   logic [3:0]  ch;
   logic [7:0]  rd_addr;
   logic [15:0] expw;
   logic [11:0] raws [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};

   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   aivf_top u_dut (.mclk(mclk), .rst(rst), .sw_range(sw_range), .sw_fmt(sw_fmt),
      .sw_diff(sw_diff), .sw_area(sw_area), .sw_base(sw_base), .conv_valid(conv_valid),
      .conv_chan(conv_chan), .conv_raw(conv_raw), .conv_over(conv_over),
      .conv_break(conv_break), .io_rd(io_rd), .io_area(io_area), .io_addr(io_addr),
      .io_data(io_data), .io_ack(io_ack), .cfg_error(cfg_error));

   aivf_cpu_model u_cpu (.mclk(mclk), .io_data(io_data), .io_ack(io_ack), .io_rd(io_rd),
      .io_area(io_area), .io_addr(io_addr));

   // -----------------------------------------------------------------
   // expected words and bus helpers
   // -----------------------------------------------------------------
   function automatic logic [15:0] exp_word(input logic [3:0] code, input logic [1:0] fmt,
                                            input logic [11:0] r, input logic ov,
                                            input logic br);
      logic [11:0] v;
      logic [11:0] n;
      logic [10:0] mag;
      v   = r ^ 12'h800;
      n   = -v;
      mag = v[11] ? ((v == 12'h800) ? 11'h7FF : n[10:0]) : v[10:0];
      if (code < 4'h5 || code > 4'h9 || fmt == 2'b10) begin
         return {1'b0, r, 1'b0, br, ov};
      end
      if (fmt == 2'b01) begin
         return {v[11], 1'b0, mag, 1'b0, br, ov};
      end
      return {v[11], 1'b0, v[10:0], 1'b0, br, ov};
   endfunction : exp_word

   task automatic conv(input logic [3:0] c, input logic [11:0] r, input logic ov,
                       input logic br);
      @(posedge mclk);
      conv_valid <= 1'b1;
      conv_chan  <= c;
      conv_raw   <= r;
      conv_over  <= ov;
      conv_break <= br;
      @(posedge mclk);
      conv_valid <= 1'b0;
      conv_raw   <= ~r;
   endtask : conv

   task automatic read_chk(input logic area, input logic [7:0] addr, input logic ea,
                           input logic [15:0] ed);
      u_cpu.read_word(area, addr, ack, data);
      `CHK(ack, ea);
      `CHK(data, ed);
   endtask : read_chk

   task automatic settle();
      repeat (6) @(posedge mclk);
   endtask : settle

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      print_verdict();
   end

   // -----------------------------------------------------------------
   // test sequence
   // -----------------------------------------------------------------
   initial begin
      rst = 1'b1; sw_range = 16'h0000; sw_fmt = 2'b00; sw_diff = 1'b0;
      sw_area = 1'b0; sw_base = 3'h0; conv_valid = 1'b0; conv_chan = 4'h0;
      conv_raw = 12'h000; conv_over = 1'b0; conv_break = 1'b0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      settle();
      read_chk(1'b0, 8'h86, 1'b1, 16'h0000);
      $display("test reset done");
      // every range code in every group, every format code, rotating base and area
      for (int k = 0; k < 12; k++) begin
         for (int f = 0; f < 4; f++) begin
            for (int g = 0; g < 4; g++) rng[4*g +: 4] = 4'((k + g) % 12);
            sw_range <= rng;
            sw_fmt   <= 2'(f);
            sw_base  <= 3'(2 * (k % 4));
            sw_area  <= 1'(k % 2);
            settle();
            for (int g = 0; g < 4; g++) begin
               raw     = raws[(k + g + f) % 4];
               ch      = 4'(4 * g + (k % 4));
               rd_addr = 8'(128 + 32 * (k % 4) + 2 * ch);
               expw    = exp_word(rng[4*g +: 4], 2'(f), raw, 1'(g % 2), 1'(g / 2));
               conv(ch, raw, 1'(g % 2), 1'(g / 2));
               read_chk(1'(k % 2), rd_addr, 1'b1, expw);
            end
         end
      end
      $display("test formats done");
      sw_diff  <= 1'b1;
      sw_area  <= 1'b1;
      sw_base  <= 3'h3;
      sw_range <= 16'h0094;
      sw_fmt   <= 2'b00;
      settle();
      `CHK(cfg_error, 1'b0);
      conv(4'h5, 12'h123, 1'b0, 1'b0);
      read_chk(1'b1, 8'hBA, 1'b1, exp_word(4'h9, 2'b00, 12'h123, 1'b0, 1'b0));
      conv(4'h3, 12'h456, 1'b0, 1'b0);
      read_chk(1'b1, 8'hB6, 1'b1, exp_word(4'h4, 2'b00, 12'h456, 1'b0, 1'b0));
      conv(4'hD, 12'hABC, 1'b1, 1'b1);
      read_chk(1'b1, 8'hBA, 1'b1, exp_word(4'h9, 2'b00, 12'h123, 1'b0, 1'b0));
      read_chk(1'b0, 8'hBA, 1'b0, 16'h0000);
      read_chk(1'b1, 8'hBB, 1'b0, 16'h0000);
      read_chk(1'b1, 8'hC0, 1'b0, 16'h0000);
      read_chk(1'b1, 8'hAE, 1'b0, 16'h0000);
      $display("test differential done");
      sw_diff <= 1'b0;
      settle();
      `CHK(cfg_error, 1'b1);
      conv(4'h0, 12'h321, 1'b0, 1'b0);
      read_chk(1'b1, 8'hA0, 1'b1, exp_word(4'h4, 2'b00, 12'h321, 1'b0, 1'b0));
      $display("test odd base done");
      print_verdict();
   end
endmodule : test_aivf_top
